// >>> rtl/dtec_pkg.sv
// package: sizes, codes, stored glyphs, types for the edit control block
package dtec_pkg;
   // display geometry
   localparam int               ROWS       = 6;
   localparam int               COLS       = 80;
   localparam int               ROW_W      = 3;
   localparam int               COL_W      = 7;
   localparam int               CODE_W     = 7;
   localparam int               CHAR_W     = 6;
   localparam int               FIFO_DEPTH = 4;
   localparam logic [ROW_W-1:0] FIRST_ROW  = 3'h0;
   localparam logic [ROW_W-1:0] LAST_ROW   = 3'h5;
   localparam logic [COL_W-1:0] FIRST_COL  = 7'h00;
   localparam logic [COL_W-1:0] LAST_COL   = 7'h4f;

   // control codes
   localparam logic [CODE_W-1:0] C_CLEAR_ENTRY     = 7'h05;
   localparam logic [CODE_W-1:0] C_ERASE_LINE      = 7'h0b;
   localparam logic [CODE_W-1:0] C_NEW_LINE        = 7'h0d;
   localparam logic [CODE_W-1:0] C_LINE_FEED       = 7'h0a;
   localparam logic [CODE_W-1:0] C_BACKSPACE       = 7'h08;
   localparam logic [CODE_W-1:0] C_MESSAGE_CANCEL  = 7'h18;
   localparam logic [CODE_W-1:0] C_START_MSG_MARK  = 7'h02;
   localparam logic [CODE_W-1:0] C_END_MSG_MARK    = 7'h03;
   localparam logic [CODE_W-1:0] C_RETURN_ORIGIN   = 7'h1e;
   localparam logic [CODE_W-1:0] C_SHIFT_RIGHT     = 7'h0e;
   localparam logic [CODE_W-1:0] C_REMOVE_CHAR     = 7'h0f;
   localparam logic [CODE_W-1:0] C_ERASE_ALL       = 7'h0c;
   localparam logic [CODE_W-1:0] C_SPLIT_SET       = 7'h11;
   localparam logic [CODE_W-1:0] C_SPLIT_RESET     = 7'h12;
   localparam logic [CODE_W-1:0] C_SPACE           = 7'h20;
   localparam logic [CODE_W-1:0] C_COLON           = 7'h3a;
   localparam logic [CODE_W-1:0] C_RUBOUT          = 7'h7f;
   localparam logic [CODE_W-1:0] C_DATA_LO         = 7'h20;
   localparam logic [CODE_W-1:0] C_LOWER_LO        = 7'h60;
   localparam logic [CODE_W-1:0] C_LOWER_FOLD      = 7'h40;

   // stored 6-bit glyphs
   localparam logic [CHAR_W-1:0] CH_BLANK   = 6'h00;
   localparam logic [CHAR_W-1:0] CH_UPARROW = 6'h3e;
   localparam logic [CHAR_W-1:0] CH_BRACKET = 6'h3d;

   // serial timing
   localparam int CLK_MHZ  = 100;
   localparam int BIT_NS   = 104167;
   localparam int RXC_W    = 20;
   localparam int RXBITS   = 8;

   typedef struct packed {
      logic [ROW_W-1:0] row;
      logic [COL_W-1:0] col;
   } dtec_cursor_s;

   typedef struct packed {
      logic              from_host;
      logic              shifted;
      logic [CODE_W-1:0] code;
   } dtec_entry_s;

   typedef enum {EX_IDLE, EX_SWEEP, EX_INS, EX_DEL} dtec_exec_e;
   typedef enum {RX_IDLE, RX_START, RX_BITS, RX_STOP} dtec_rx_e;
endpackage : dtec_pkg

// >>> rtl/dtec_top.sv
// edit control: input fifo, serial receiver, command interpreter, display memory
// Functional notes
// - general clear-entry blanks whole display, homes cursor, keeps delineators
// - split clear-entry blanks unprotected fields, cursor right of first delineator
// - general erase-line blanks cursor line, cursor to column zero
// - split erase-line blanks unprotected part, cursor right of line delineator
// - general new-line writes up-arrow, cursor to column zero of next line
// - split new-line writes up-arrow, cursor right of next line delineator
// - new-line on bottom line wraps to top line
// - line feed moves cursor down one row with wrap, data untouched
// - backspace moves left, stops at column zero or right of delineator
// - message cancel recognised, display unchanged
// - start and end message markers write bracket at cursor
// - general home puts cursor at top-left
// - split home goes right of first delineator, else top-left
// - insert shifts line right from cursor, drops last, cursor stays
// - delete shifts line left onto cursor, blank at end, cursor stays
// - shifted space advances cursor, stopping at column 79, data untouched
// - forward space keyboard only; on-line sends plain space code
// - control codes execute as commands; only new-line and the message markers write a glyph
// - printable codes compressed to 6 bits and stored; keyboard codes also sent out when on-line
// - memory holds six rows of eighty characters
// - host frame start, 7 data, parity, stop; parity checked
// - rows 0 to 5, columns 0 to 79
// - per-line delineator holds latest colon entered in general format; none means unprotected
// - clear display blanks all, homes, general format, clears delineators

module dtec_fifo #(
   parameter int W     = 9,
   parameter int DEPTH = 4
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   // fill side
   input  wire logic         in_valid_in,
   output logic              in_ready_out,
   input  wire logic [W-1:0] in_data_in,
   // drain side
   output logic              out_valid_out,
   input  wire logic         out_ready_in,
   output logic [W-1:0]      out_data_out
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0]  mem_q [DEPTH];
   logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [PW:0]   cnt_q, cnt_d;
   logic          push, pop;

   always_comb begin
      in_ready_out  = (cnt_q != (PW+1)'(DEPTH));
      out_valid_out = (cnt_q != '0);
      out_data_out  = mem_q[rp_q];
      push = in_valid_in && in_ready_out;
      pop  = out_valid_out && out_ready_in;
      wp_d = push ? wp_q + 1'b1 : wp_q;
      rp_d = pop ? rp_q + 1'b1 : rp_q;
      cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
      if (push) mem_q[wp_q] <= in_data_in;
   end
endmodule : dtec_fifo

module dtec_top
   import dtec_pkg::*;
#(
   parameter int BIT_NS_P = BIT_NS
) (
   // clock and reset
   input  wire logic              mclk_in,
   input  wire logic              reset_in,
   // keyboard pins
   input  wire logic              kbd_strobe_in,
   input  wire logic              kbd_shift_in,
   input  wire logic [CODE_W-1:0] kbd_code_in,
   // host serial line
   input  wire logic              ser_rx_in,
   input  wire logic              online_in,
   // outgoing codes
   output logic                   tx_valid_out,
   output logic [CODE_W-1:0]      tx_code_out,
   // display read port
   input  wire logic [ROW_W-1:0]  disp_row_in,
   input  wire logic [COL_W-1:0]  disp_col_in,
   output logic [CHAR_W-1:0]      disp_char_out,
   // status
   output logic [ROW_W-1:0]       cursor_row_out,
   output logic [COL_W-1:0]       cursor_col_out,
   output logic                   split_format_out,
   output logic                   entry_ready_out,
   output logic                   busy_out,
   output logic                   rx_error_out,
   output logic                   msg_cancel_out
);
   localparam int                BIT_CYC  = (BIT_NS_P * CLK_MHZ) / 1000;
   localparam logic [RXC_W-1:0]  BIT_LAST = RXC_W'(BIT_CYC - 1);
   localparam logic [RXC_W-1:0]  HALF_LAST = RXC_W'(BIT_CYC / 2 - 1);
   localparam int                SW = CODE_W + 3;

   // pin synchronisers: a bit changes once stages two and three agree
   logic [SW-1:0] s1_q, s2_q, s3_q, flt_q, flt_d, pins;
   logic          kb_prev_q;
   always_comb begin
      pins  = {ser_rx_in, kbd_strobe_in, kbd_shift_in, kbd_code_in};
      flt_d = (s2_q & s3_q) | (flt_q & (s2_q ^ s3_q));
   end
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         s1_q      <= '1;
         s2_q      <= '1;
         s3_q      <= '1;
         flt_q     <= '1;
         kb_prev_q <= 1'b1;
      end else begin
         s1_q      <= pins;
         s2_q      <= s1_q;
         s3_q      <= s2_q;
         flt_q     <= flt_d;
         kb_prev_q <= flt_q[SW-2];
      end
   end
   logic rx_lvl, kb_evt;
   assign rx_lvl = flt_q[SW-1];
   assign kb_evt = flt_q[SW-2] && !kb_prev_q;

   // host frame receiver
   dtec_rx_e          rx_q, rx_d;
   logic [RXC_W-1:0]  rc_q, rc_d;
   logic [3:0]        ri_q, ri_d;
   logic [RXBITS-1:0] rs_q, rs_d;
   logic              hp_q, hp_d, rerr_d, rerr_q;
   logic [CODE_W-1:0] hc_q, hc_d;
   logic              fifo_in_rdy, take_kb;
   always_comb begin
      rx_d = rx_q;
      rc_d = (rc_q == '0) ? rc_q : rc_q - 1'b1;
      ri_d = ri_q;
      rs_d = rs_q;
      hp_d = hp_q && !(fifo_in_rdy && !take_kb);
      hc_d = hc_q;
      rerr_d = 1'b0;
      unique case (rx_q)
         RX_IDLE: if (!rx_lvl) begin
            rx_d = RX_START;
            rc_d = HALF_LAST;
         end
         RX_START: if (rc_q == '0) begin
            rx_d = rx_lvl ? RX_IDLE : RX_BITS;
            rc_d = BIT_LAST;
            ri_d = '0;
         end
         RX_BITS: if (rc_q == '0) begin
            rs_d = {rx_lvl, rs_q[RXBITS-1:1]};
            ri_d = ri_q + 1'b1;
            rc_d = BIT_LAST;
            if (ri_q == 4'(RXBITS - 1)) rx_d = RX_STOP;
         end
         RX_STOP: if (rc_q == '0) begin
            rx_d = RX_IDLE;
            if (rx_lvl && !(^rs_q)) begin
               hp_d = 1'b1;
               hc_d = rs_q[CODE_W-1:0];
            end else begin
               rerr_d = 1'b1;
            end
         end
      endcase
   end
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         rx_q   <= RX_IDLE;
         rc_q   <= '0;
         ri_q   <= '0;
         rs_q   <= '0;
         hp_q   <= 1'b0;
         hc_q   <= '0;
         rerr_q <= 1'b0;
      end else begin
         rx_q   <= rx_d;
         rc_q   <= rc_d;
         ri_q   <= ri_d;
         rs_q   <= rs_d;
         hp_q   <= hp_d;
         hc_q   <= hc_d;
         rerr_q <= rerr_d;
      end
   end

   // entry fifo; keyboard first, host word waits in its holding register
   dtec_entry_s fin, fout;
   logic        fout_v, fout_rdy;
   assign take_kb = kb_evt;
   always_comb begin
      fin.from_host = !take_kb;
      fin.shifted   = take_kb && flt_q[CODE_W];
      fin.code      = take_kb ? flt_q[CODE_W-1:0] : hc_q;
   end
   dtec_fifo #(
      .W     ($bits(dtec_entry_s)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (mclk_in),
      .rst_in        (reset_in),
      .in_valid_in   (take_kb || hp_q),
      .in_ready_out  (fifo_in_rdy),
      .in_data_in    (fin),
      .out_valid_out (fout_v),
      .out_ready_in  (fout_rdy),
      .out_data_out  (fout)
   );

   // display memory and delineators
   logic [CHAR_W-1:0] mem_q [ROWS][COLS];
   logic [ROWS-1:0]   dv_q, dv_d;
   logic [COL_W-1:0]  dc_q [ROWS];
   logic [COL_W-1:0]  dc_d [ROWS];
   logic              we;
   dtec_cursor_s      wa, cur_q, cur_d, org;
   logic [CHAR_W-1:0] wdat, ch;
   dtec_exec_e        ex_q, ex_d;
   logic [ROW_W-1:0]  swr_q, swr_d, swe_q, swe_d;
   logic [COL_W-1:0]  wk_q, wk_d;
   logic              sp_q, sp_d, txv_d, txv_q, mc_d, mc_q;
   logic [CODE_W-1:0] txc_d, txc_q;
   logic [ROW_W-1:0]  nrow;

   function automatic logic [COL_W-1:0] start_col(input logic [ROW_W-1:0] r,
                                                  input logic s);
      start_col = FIRST_COL;
      if (s && dv_q[r]) start_col = (dc_q[r] == LAST_COL) ? LAST_COL : dc_q[r] + 1'b1;
   endfunction : start_col

   always_comb begin
      org = '{row: FIRST_ROW, col: FIRST_COL};
      for (int r = ROWS - 1; r >= 0; r--) begin
         if (sp_q && dv_q[r]) org = '{row: ROW_W'(r), col: start_col(ROW_W'(r), 1'b1)};
      end
      nrow = (cur_q.row == LAST_ROW) ? FIRST_ROW : cur_q.row + 1'b1;
      ch = (fout.code >= C_LOWER_LO) ? CHAR_W'(fout.code - C_LOWER_FOLD)
                                     : CHAR_W'(fout.code - C_DATA_LO);
   end

   always_comb begin
      ex_d  = ex_q;
      cur_d = cur_q;
      swr_d = swr_q;
      swe_d = swe_q;
      wk_d  = wk_q;
      sp_d  = sp_q;
      dv_d  = dv_q;
      dc_d  = dc_q;
      we    = 1'b0;
      wa    = cur_q;
      wdat  = CH_BLANK;
      txv_d = 1'b0;
      txc_d = txc_q;
      mc_d  = 1'b0;
      fout_rdy = (ex_q == EX_IDLE);
      unique case (ex_q)
         EX_IDLE: if (fout_v) begin
            if (fout.code < C_DATA_LO) begin
               unique case (fout.code)
                  C_ERASE_ALL: begin
                     sp_d  = 1'b0;
                     dv_d  = '0;
                     cur_d = '{row: FIRST_ROW, col: FIRST_COL};
                     swr_d = FIRST_ROW;
                     swe_d = LAST_ROW;
                     wk_d  = FIRST_COL;
                     ex_d  = EX_SWEEP;
                  end
                  C_CLEAR_ENTRY: begin
                     cur_d = org;
                     swr_d = FIRST_ROW;
                     swe_d = LAST_ROW;
                     wk_d  = start_col(FIRST_ROW, sp_q);
                     ex_d  = EX_SWEEP;
                  end
                  C_ERASE_LINE: begin
                     cur_d.col = start_col(cur_q.row, sp_q);
                     swr_d = cur_q.row;
                     swe_d = cur_q.row;
                     wk_d  = start_col(cur_q.row, sp_q);
                     ex_d  = EX_SWEEP;
                  end
                  C_NEW_LINE: begin
                     we    = 1'b1;
                     wdat  = CH_UPARROW;
                     cur_d = '{row: nrow, col: start_col(nrow, sp_q)};
                  end
                  C_LINE_FEED: cur_d.row = nrow;
                  C_BACKSPACE: begin
                     if (cur_q.col > start_col(cur_q.row, sp_q))
                        cur_d.col = cur_q.col - 1'b1;
                  end
                  C_MESSAGE_CANCEL: mc_d = 1'b1;
                  C_START_MSG_MARK, C_END_MSG_MARK: begin
                     we   = 1'b1;
                     wdat = CH_BRACKET;
                     if (cur_q.col != LAST_COL) cur_d.col = cur_q.col + 1'b1;
                  end
                  C_RETURN_ORIGIN: cur_d = org;
                  C_SHIFT_RIGHT: begin
                     wk_d = LAST_COL;
                     ex_d = EX_INS;
                  end
                  C_REMOVE_CHAR: begin
                     wk_d = cur_q.col;
                     ex_d = EX_DEL;
                  end
                  C_SPLIT_SET: begin
                     sp_d = 1'b1;
                     cur_d = '{row: FIRST_ROW, col: FIRST_COL};
                     for (int r = ROWS - 1; r >= 0; r--) begin
                        if (dv_q[r]) cur_d = '{row: ROW_W'(r), col: start_col(ROW_W'(r), 1'b1)};
                     end
                  end
                  C_SPLIT_RESET: sp_d = 1'b0;
                  default: ;
               endcase
            end else if (fout.code != C_RUBOUT) begin
               if (!fout.from_host && fout.shifted && fout.code == C_SPACE) begin
                  if (cur_q.col != LAST_COL) cur_d.col = cur_q.col + 1'b1;
                  txv_d = online_in;
                  txc_d = C_SPACE;
               end else begin
                  we   = 1'b1;
                  wdat = ch;
                  if (cur_q.col != LAST_COL) cur_d.col = cur_q.col + 1'b1;
                  if (fout.code == C_COLON && !sp_q) begin
                     dv_d[cur_q.row] = 1'b1;
                     dc_d[cur_q.row] = cur_q.col;
                  end
                  txv_d = !fout.from_host && online_in;
                  txc_d = fout.code;
               end
            end
         end
         EX_SWEEP: begin
            we = 1'b1;
            wa = '{row: swr_q, col: wk_q};
            wk_d = wk_q + 1'b1;
            if (wk_q == LAST_COL) begin
               if (swr_q == swe_q) begin
                  ex_d = EX_IDLE;
               end else begin
                  swr_d = swr_q + 1'b1;
                  wk_d  = start_col(swr_q + 1'b1, sp_q);
               end
            end
         end
         EX_INS: begin
            we = 1'b1;
            wa = '{row: cur_q.row, col: wk_q};
            if (wk_q == cur_q.col) begin
               ex_d = EX_IDLE;
            end else begin
               wdat = mem_q[cur_q.row][wk_q - 1'b1];
               wk_d = wk_q - 1'b1;
            end
         end
         EX_DEL: begin
            we = 1'b1;
            wa = '{row: cur_q.row, col: wk_q};
            if (wk_q == LAST_COL) begin
               ex_d = EX_IDLE;
            end else begin
               wdat = mem_q[cur_q.row][wk_q + 1'b1];
               wk_d = wk_q + 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         ex_q  <= EX_IDLE;
         cur_q <= '{row: FIRST_ROW, col: FIRST_COL};
         swr_q <= FIRST_ROW;
         swe_q <= FIRST_ROW;
         wk_q  <= FIRST_COL;
         sp_q  <= 1'b0;
         dv_q  <= '0;
         txv_q <= 1'b0;
         txc_q <= '0;
         mc_q  <= 1'b0;
         for (int r = 0; r < ROWS; r++) dc_q[r] <= FIRST_COL;
      end else begin
         ex_q  <= ex_d;
         cur_q <= cur_d;
         swr_q <= swr_d;
         swe_q <= swe_d;
         wk_q  <= wk_d;
         sp_q  <= sp_d;
         dv_q  <= dv_d;
         txv_q <= txv_d;
         txc_q <= txc_d;
         mc_q  <= mc_d;
         dc_q  <= dc_d;
      end
   end

   // memory write and display read
   always_ff @(posedge mclk_in) begin
      if (we) mem_q[wa.row][wa.col] <= wdat;
      disp_char_out <= mem_q[disp_row_in][disp_col_in];
   end

   assign tx_valid_out     = txv_q;
   assign tx_code_out      = txc_q;
   assign cursor_row_out   = cur_q.row;
   assign cursor_col_out   = cur_q.col;
   assign split_format_out = sp_q;
   assign entry_ready_out  = fifo_in_rdy;
   assign busy_out         = (ex_q != EX_IDLE);
   assign rx_error_out     = rerr_q;
   assign msg_cancel_out   = mc_q;
endmodule : dtec_top

// >>> verification/dtec_chk_sva.sv
// checker: port-level properties of the edit control block
module dtec_chk
   import dtec_pkg::*;
(
   // clock and reset
   input wire logic              mclk_in,
   input wire logic              reset_in,
   // inputs watched
   input wire logic              kbd_strobe_in,
   input wire logic [CODE_W-1:0] kbd_code_in,
   input wire logic              online_in,
   // outputs watched
   input wire logic              tx_valid_out,
   input wire logic [CODE_W-1:0] tx_code_out,
   input wire logic [ROW_W-1:0]  cursor_row_out,
   input wire logic [COL_W-1:0]  cursor_col_out,
   input wire logic              split_format_out,
   input wire logic              entry_ready_out,
   input wire logic              busy_out,
   input wire logic              rx_error_out,
   input wire logic              msg_cancel_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   property p_reset_state;
      $fell(reset_in) |-> cursor_row_out == FIRST_ROW && cursor_col_out == FIRST_COL
         && !split_format_out && !busy_out && entry_ready_out && !tx_valid_out;
   endproperty
   a_reset_state : assert property (p_reset_state) else $error("state after reset wrong");
   property p_row_range;
      cursor_row_out <= LAST_ROW;
   endproperty
   a_row_range : assert property (p_row_range) else $error("cursor row out of range");
   property p_col_range;
      cursor_col_out <= LAST_COL;
   endproperty
   a_col_range : assert property (p_col_range) else $error("cursor column out of range");
   property p_tx_data;
      tx_valid_out |-> tx_code_out >= C_DATA_LO && tx_code_out != C_RUBOUT;
   endproperty
   a_tx_data : assert property (p_tx_data) else $error("control code sent out");
   property p_tx_online;
      tx_valid_out |-> $past(online_in);
   endproperty
   a_tx_online : assert property (p_tx_online) else $error("code sent while off-line");
   property p_tx_pulse;
      tx_valid_out |=> !tx_valid_out;
   endproperty
   a_tx_pulse : assert property (p_tx_pulse) else $error("send pulse too long");
   property p_cancel_still;
      msg_cancel_out |-> $stable(cursor_row_out) && $stable(cursor_col_out) && !busy_out;
   endproperty
   a_cancel_still : assert property (p_cancel_still) else $error("cancel moved cursor");
   property p_erase_all;
      $rose(kbd_strobe_in) && kbd_code_in == C_ERASE_ALL && !busy_out |-> ##[4:12]
         (!split_format_out && cursor_row_out == FIRST_ROW && cursor_col_out == FIRST_COL);
   endproperty
   a_erase_all : assert property (p_erase_all) else $error("erase all did not home");
   property p_err_pulse;
      rx_error_out |=> !rx_error_out;
   endproperty
   a_err_pulse : assert property (p_err_pulse) else $error("receive error pulse too long");

   c_tx     : cover property (tx_valid_out);
   c_cancel : cover property (msg_cancel_out);
   c_sweep  : cover property ($rose(busy_out));
endmodule : dtec_chk

bind dtec_top dtec_chk dtec_chk_i (
   .mclk_in(mclk_in), .reset_in(reset_in), .kbd_strobe_in(kbd_strobe_in),
   .kbd_code_in(kbd_code_in), .online_in(online_in), .tx_valid_out(tx_valid_out),
   .tx_code_out(tx_code_out), .cursor_row_out(cursor_row_out),
   .cursor_col_out(cursor_col_out), .split_format_out(split_format_out),
   .entry_ready_out(entry_ready_out), .busy_out(busy_out), .rx_error_out(rx_error_out),
   .msg_cancel_out(msg_cancel_out)
);

// >>> verification/dtec_host_model.sv
// far side model: host computer driving the serial receive line
module dtec_host_model
   import dtec_pkg::*;
#(
   parameter int BIT_CYC = 10
) (
   input  wire logic clk_in,
   output logic      ser_rx_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial ser_rx_out = 1'b1;

   // start, seven data lsb first, even parity, stop; line idles high
   task automatic send(input logic [CODE_W-1:0] d, input logic bad_par);
      logic [9:0] fr;
      fr = {1'b1, ^d ^ bad_par, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         ser_rx_out <= fr[i];
         repeat (BIT_CYC) @(posedge clk_in);
      end
   endtask : send
endmodule : dtec_host_model

// >>> verification/tb.sv
// testbench: keyboard and host traffic against the edit control block
module tb
   import dtec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              mclk_in, reset_in, kbd_strobe_in, kbd_shift_in, ser_rx_in, online_in;
   logic [CODE_W-1:0] kbd_code_in, tx_code_out;
   logic [CODE_W-1:0] tx_last = '0;
   logic [ROW_W-1:0]  disp_row_in, cursor_row_out;
   logic [COL_W-1:0]  disp_col_in, cursor_col_out;
   logic [CHAR_W-1:0] disp_char_out;
   logic              tx_valid_out, split_format_out, entry_ready_out;
   logic              busy_out, rx_error_out, msg_cancel_out;
   int                errors = 0, cmp_count = 0, tx_n = 0, mc_n = 0, er_n = 0;

   dtec_top #(.BIT_NS_P(100)) dtec_top_i (
      .mclk_in(mclk_in), .reset_in(reset_in), .kbd_strobe_in(kbd_strobe_in),
      .kbd_shift_in(kbd_shift_in), .kbd_code_in(kbd_code_in), .ser_rx_in(ser_rx_in),
      .online_in(online_in), .tx_valid_out(tx_valid_out), .tx_code_out(tx_code_out),
      .disp_row_in(disp_row_in), .disp_col_in(disp_col_in), .disp_char_out(disp_char_out),
      .cursor_row_out(cursor_row_out), .cursor_col_out(cursor_col_out),
      .split_format_out(split_format_out), .entry_ready_out(entry_ready_out),
      .busy_out(busy_out), .rx_error_out(rx_error_out), .msg_cancel_out(msg_cancel_out));
   dtec_host_model #(.BIT_CYC(10)) dtec_host_model_i (.clk_in(mclk_in), .ser_rx_out(ser_rx_in));

   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end

   always @(posedge mclk_in) begin
      if (tx_valid_out === 1'b1) begin
         tx_n    <= tx_n + 1;
         tx_last <= tx_code_out;
      end
      if (msg_cancel_out === 1'b1) mc_n <= mc_n + 1;
      if (rx_error_out === 1'b1) er_n <= er_n + 1;
   end

   task automatic clk(input int n);
      repeat (n) @(posedge mclk_in);
   endtask : clk

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic chk_cur(input int r, input int c, input int s);
      #1;
      chk("cursor_row", 8'(cursor_row_out), 8'(r));
      chk("cursor_col", 8'(cursor_col_out), 8'(c));
      chk("split", 8'(split_format_out), 8'(s));
      @(posedge mclk_in);
   endtask : chk_cur

   task automatic chk_mem(input int r, input int c, input logic [CHAR_W-1:0] e);
      disp_row_in <= ROW_W'(r);
      disp_col_in <= COL_W'(c);
      clk(2);
      #1;
      chk("char", 8'(disp_char_out), 8'(e));
      @(posedge mclk_in);
   endtask : chk_mem

   // one key: code held, strobe high 4 cycles, then wait out any sweep
   task automatic key(input logic [CODE_W-1:0] c, input logic sh = 1'b0);
      int n;
      n = 0;
      kbd_code_in  <= c;
      kbd_shift_in <= sh;
      clk(4);
      kbd_strobe_in <= 1'b1;
      clk(4);
      kbd_strobe_in <= 1'b0;
      clk(4);
      #1;
      while (busy_out === 1'b1 && n < 1000) begin
         clk(1);
         #1;
         n++;
      end
      if (n >= 1000) errors++;
      clk(4);
   endtask : key

   task automatic host(input logic [CODE_W-1:0] d, input logic bad);
      dtec_host_model_i.send(d, bad);
      clk(20);
   endtask : host

   task automatic t_erase_all;
      key(C_ERASE_ALL);
      chk_cur(0, 0, 0);
      chk_mem(5, 79, CH_BLANK);
      chk_mem(2, 40, CH_BLANK);
      $display("test erase_all done");
   endtask : t_erase_all

   task automatic t_lines;
      key(7'h41);
      chk_mem(0, 0, 6'h21);
      chk("tx_code", 8'(tx_last), 8'h41);
      key(C_LINE_FEED);
      chk_cur(1, 1, 0);
      chk_mem(0, 1, CH_BLANK);
      key(C_NEW_LINE);
      chk_mem(1, 1, CH_UPARROW);
      chk_cur(2, 0, 0);
      for (int i = 0; i < 4; i++) key(C_LINE_FEED);
      chk_cur(0, 0, 0);
      for (int i = 0; i < 5; i++) key(C_LINE_FEED);
      key(C_NEW_LINE);
      chk_cur(0, 0, 0);
      chk_mem(5, 0, CH_UPARROW);
      key(7'h42);
      chk("tx_count", 8'(tx_n), 8'h02);
      key(C_ERASE_LINE);
      chk_mem(0, 0, CH_BLANK);
      chk_cur(0, 0, 0);
      $display("test lines done");
   endtask : t_lines

   task automatic t_edit;
      key(7'h41);
      key(7'h42);
      key(C_RETURN_ORIGIN);
      chk_cur(0, 0, 0);
      key(C_BACKSPACE);
      chk_cur(0, 0, 0);
      key(C_SHIFT_RIGHT);
      chk_mem(0, 0, CH_BLANK);
      chk_mem(0, 2, 6'h22);
      chk_cur(0, 0, 0);
      key(C_REMOVE_CHAR);
      chk_mem(0, 1, 6'h22);
      chk_mem(0, 79, CH_BLANK);
      key(C_SPACE, 1'b1);
      chk_cur(0, 1, 0);
      chk_mem(0, 0, 6'h21);
      chk("tx_code", 8'(tx_last), 8'h20);
      $display("test edit done");
   endtask : t_edit

   task automatic t_host;
      key(C_START_MSG_MARK);
      chk_mem(0, 1, CH_BRACKET);
      host(C_END_MSG_MARK, 1'b0);
      chk_mem(0, 2, CH_BRACKET);
      host(7'h43, 1'b0);
      chk_mem(0, 3, 6'h23);
      host(C_MESSAGE_CANCEL, 1'b0);
      chk("cancel", 8'(mc_n), 8'h01);
      chk_cur(0, 4, 0);
      host(7'h44, 1'b1);
      chk("rx_error", 8'(er_n), 8'h01);
      chk_mem(0, 4, CH_BLANK);
      $display("test host done");
   endtask : t_host

   task automatic t_split;
      int n0;
      key(C_ERASE_ALL);
      key(7'h41);
      key(C_COLON);
      key(7'h42);
      key(C_SPLIT_SET);
      chk_cur(0, 2, 1);
      key(C_LINE_FEED);
      key(C_RETURN_ORIGIN);
      chk_cur(0, 2, 1);
      key(C_BACKSPACE);
      chk_cur(0, 2, 1);
      key(C_ERASE_LINE);
      chk_mem(0, 2, CH_BLANK);
      chk_mem(0, 0, 6'h21);
      chk_cur(0, 2, 1);
      key(7'h43);
      key(C_CLEAR_ENTRY);
      chk_mem(0, 2, CH_BLANK);
      chk_mem(0, 1, 6'h1a);
      chk_cur(0, 2, 1);
      key(C_NEW_LINE);
      chk_mem(0, 2, CH_UPARROW);
      chk_cur(1, 0, 1);
      key(C_SPLIT_RESET);
      key(C_CLEAR_ENTRY);
      chk_mem(0, 0, CH_BLANK);
      chk_cur(0, 0, 0);
      key(C_SPLIT_SET);
      chk_cur(0, 2, 1);
      n0 = tx_n;
      online_in <= 1'b0;
      key(7'h45);
      chk("tx_offline", 8'(tx_n), 8'(n0));
      chk_mem(0, 2, 6'h25);
      online_in <= 1'b1;
      $display("test split done");
   endtask : t_split

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test

   initial begin
      reset_in      = 1'b1;
      kbd_strobe_in = 1'b0;
      kbd_shift_in  = 1'b0;
      kbd_code_in   = '0;
      online_in     = 1'b1;
      disp_row_in   = '0;
      disp_col_in   = '0;
      clk(16);
      reset_in <= 1'b0;
      clk(2);
      t_erase_all;
      t_lines;
      t_edit;
      t_host;
      t_split;
      finish_test;
   end

   initial begin
      clk(40000);
      errors++;
      finish_test;
   end
endmodule : tb
